// ---- pkg/shadow_ctl_pkg.sv ----
// package: constants and types for the interrupt mode and shadow set controller
package shadow_ctl_pkg;
    // register map of the plain register port (word indices)
    localparam logic [3:0]  ADDR_SHADOW_CTRL = 4'h0;
    localparam logic [3:0]  ADDR_VECTOR_MAP  = 4'h1;
    localparam logic [3:0]  ADDR_INT_MODE    = 4'h2;
    localparam logic [3:0]  ADDR_CAPABILITY3 = 4'h3;
    localparam logic [3:0]  ADDR_PRIV_STATE  = 4'h4;
    // shadow_set_control field positions
    localparam int          POS_HSS          = 26;
    localparam int          POS_ESS          = 12;
    localparam int          POS_PSS          = 6;
    localparam int          POS_CSS          = 0;
    // capability_register_three field positions
    localparam int          POS_VECTORED_IRQ_PRESENT_BIT_BIT     = 5;
    localparam int          POS_VEXT_BIT     = 6;
    // reset values
    localparam logic [3:0]  RST_SET          = 4'h0;
    localparam logic [31:0] RST_VMAP         = 32'h0000_0000;
    // address map
    localparam logic [31:0] USER_SEG_TOP     = 32'h7fff_ffff;
    localparam logic [31:0] UNC_SEG_LO       = 32'ha000_0000;
    localparam logic [31:0] UNC_SEG_HI       = 32'hbfff_ffff;
    localparam logic [31:0] DBG_SEG_LO       = 32'hff20_0000;
    localparam logic [31:0] DBG_SEG_HI       = 32'hff3f_ffff;

    typedef enum logic [1:0] {
        MODE_COMPAT,
        MODE_VECTORED,
        MODE_EXTERNAL
    } int_mode_t;

    typedef enum logic [1:0] {
        PRIV_USER,
        PRIV_KERNEL,
        PRIV_DEBUG
    } priv_t;

    // event presented by the pipeline
    typedef struct packed {
        logic       reset_evt;
        logic       debug_evt;
        logic       nmi_evt;
        logic       irq_evt;
        logic       exc_evt;
        logic       exception_return;
        logic [2:0] vec_num;
        logic [3:0] ext_set;
    } event_t;

    typedef struct packed {
        logic [3:0] current_shadow_set;
        logic [3:0] previous_shadow_set;
        logic [3:0] exception_shadow_set;
        logic [31:0] vmap;
        int_mode_t  mode;
        priv_t      priv;
        logic [31:0] rdata;
    } state_t;
endpackage : shadow_ctl_pkg

// ---- rtl/shadow_ctl.sv ----
// interrupt mode, shadow register set and privilege/address segment control
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module shadow_ctl
    import shadow_ctl_pkg::*;
#(
    parameter int NUM_SETS = 4
) (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // register port
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // interrupt sources
    input  wire logic [5:0]  HW_IRQ_I,
    input  wire logic [1:0]  SW_IRQ_I,
    input  wire logic        TIMER_IRQ_I,
    input  wire logic        EXT_CTRL_PRESENT_I,
    // pipeline events
    input  wire event_t      EVENT_I,
    input  wire logic        PREV_SET_ACCESS_I,
    // status to the pipeline
    output logic             IRQ_PENDING_O,
    output logic      [1:0]  ENTRY_KIND_O,
    output logic      [3:0]  GPR_SET_O,
    output logic      [1:0]  MODE_O,
    output logic      [1:0]  PRIV_O,
    // address classification
    input  wire logic [31:0] VADDR_I,
    output logic             ADDR_USER_O,
    output logic             ADDR_UNCACHED_O,
    output logic             ADDR_DEBUG_O
);

    localparam logic [3:0] HIGHEST_SHADOW_SET = 4'(NUM_SETS - 1);

    state_t     q;
    state_t     d;
    logic [8:0] irq_lines;
    logic       entry;
    logic [3:0] new_set;

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic [3:0] clip_set(input logic [3:0] s);
        clip_set = (s > HIGHEST_SHADOW_SET) ? RST_SET : s;
    endfunction : clip_set

    function automatic logic [3:0] map_set(input logic [31:0] m,
                                           input logic [2:0]  v);
        map_set = m[{v, 2'b00} +: 4];
    endfunction : map_set

    // --------------------------------------------------------------------
    // interrupt sources and entry selection
    // --------------------------------------------------------------------
    assign irq_lines     = {TIMER_IRQ_I, HW_IRQ_I, SW_IRQ_I};
    assign IRQ_PENDING_O = |irq_lines;
    assign entry = EVENT_I.debug_evt | EVENT_I.nmi_evt | EVENT_I.irq_evt | EVENT_I.exc_evt;

    always_comb begin
        // reset handled by RST_I; debug over nmi over interrupt
        if (EVENT_I.debug_evt) begin
            ENTRY_KIND_O = 2'h3;
        end else if (EVENT_I.nmi_evt) begin
            ENTRY_KIND_O = 2'h2;
        end else if (EVENT_I.irq_evt) begin
            ENTRY_KIND_O = 2'h1;
        end else begin
            ENTRY_KIND_O = 2'h0;
        end
    end

    always_comb begin
        new_set = q.exception_shadow_set;
        if (EVENT_I.irq_evt && !EVENT_I.nmi_evt && !EVENT_I.debug_evt) begin
            unique case (q.mode)
                MODE_VECTORED: new_set = map_set(q.vmap, EVENT_I.vec_num);
                MODE_EXTERNAL: new_set = EVENT_I.ext_set;
                default:       new_set = q.exception_shadow_set;
            endcase
        end
        new_set = clip_set(new_set);
    end

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb begin
        d       = q;
        d.rdata = 32'h0000_0000;
        if (WR_I) begin
            unique case (ADDR_I)
                ADDR_SHADOW_CTRL: begin
                    d.exception_shadow_set = clip_set(WDATA_I[POS_ESS +: 4]);
                    d.previous_shadow_set = clip_set(WDATA_I[POS_PSS +: 4]);
                end
                ADDR_VECTOR_MAP:  d.vmap = WDATA_I;
                ADDR_INT_MODE: begin
                    if (WDATA_I[1:0] == 2'h1) begin
                        d.mode = MODE_VECTORED;
                    end else if (WDATA_I[1:0] == 2'h2 && EXT_CTRL_PRESENT_I) begin
                        d.mode = MODE_EXTERNAL;
                    end else begin
                        d.mode = MODE_COMPAT;
                    end
                end
                default: ;
            endcase
        end
        if (RD_I) begin
            unique case (ADDR_I)
                ADDR_SHADOW_CTRL: begin
                    d.rdata[POS_HSS +: 4] = HIGHEST_SHADOW_SET;
                    d.rdata[POS_ESS +: 4] = q.exception_shadow_set;
                    d.rdata[POS_PSS +: 4] = q.previous_shadow_set;
                    d.rdata[POS_CSS +: 4] = q.current_shadow_set;
                end
                ADDR_VECTOR_MAP:  d.rdata = q.vmap;
                ADDR_INT_MODE:    d.rdata[1:0] = q.mode;
                ADDR_CAPABILITY3: begin
                    d.rdata[POS_VECTORED_IRQ_PRESENT_BIT_BIT] = 1'b1;
                    d.rdata[POS_VEXT_BIT] = EXT_CTRL_PRESENT_I;
                end
                ADDR_PRIV_STATE:  d.rdata[1:0] = q.priv;
                default: ;
            endcase
        end
        if (entry) begin
            d.previous_shadow_set  = q.current_shadow_set;
            d.current_shadow_set  = new_set;
            d.priv = EVENT_I.debug_evt ? PRIV_DEBUG : PRIV_KERNEL;
        end else if (EVENT_I.exception_return) begin
            d.current_shadow_set  = q.previous_shadow_set;
            d.priv = (q.priv == PRIV_DEBUG) ? PRIV_KERNEL : PRIV_USER;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            q.current_shadow_set   <= RST_SET;
            q.previous_shadow_set   <= RST_SET;
            q.exception_shadow_set   <= RST_SET;
            q.vmap  <= RST_VMAP;
            q.mode  <= MODE_COMPAT;
            q.priv  <= PRIV_KERNEL;
            q.rdata <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    // normal accesses use current set; previous set access for the special moves
    assign GPR_SET_O = PREV_SET_ACCESS_I ? q.previous_shadow_set : q.current_shadow_set;
    assign RDATA_O   = q.rdata;
    assign MODE_O    = q.mode;
    assign PRIV_O    = q.priv;

    assign ADDR_USER_O     = (VADDR_I <= USER_SEG_TOP);
    assign ADDR_UNCACHED_O = (VADDR_I >= UNC_SEG_LO) && (VADDR_I <= UNC_SEG_HI);
    assign ADDR_DEBUG_O    = (q.priv == PRIV_DEBUG) && (VADDR_I >= DBG_SEG_LO)
                             && (VADDR_I <= DBG_SEG_HI);

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    chk_entry_saves_css: assert property (@(posedge CLK_I) disable iff (RST_I)
        entry |=> q.previous_shadow_set == $past(q.current_shadow_set)) else $error("previous set not saved");
    chk_exception_return_restores: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!entry && EVENT_I.exception_return) |=> q.current_shadow_set == $past(q.previous_shadow_set)) else $error("set not restored");
    chk_vec_map_used: assert property (@(posedge CLK_I) disable iff (RST_I)
        (EVENT_I.irq_evt && !EVENT_I.nmi_evt && !EVENT_I.debug_evt && q.mode == MODE_VECTORED)
        |=> q.current_shadow_set == clip_set(map_set($past(q.vmap), $past(EVENT_I.vec_num))))
        else $error("vector map not used");
    chk_ext_set_used: assert property (@(posedge CLK_I) disable iff (RST_I)
        (EVENT_I.irq_evt && !EVENT_I.nmi_evt && !EVENT_I.debug_evt && q.mode == MODE_EXTERNAL)
        |=> q.current_shadow_set == clip_set($past(EVENT_I.ext_set))) else $error("external set ignored");
    chk_exc_ess_used: assert property (@(posedge CLK_I) disable iff (RST_I)
        (EVENT_I.exc_evt && !EVENT_I.irq_evt) |=> q.current_shadow_set == $past(q.exception_shadow_set))
        else $error("exception set wrong");
    chk_cap_vectored_irq_present_bit_one: assert property (@(posedge CLK_I) disable iff (RST_I)
        (RD_I && ADDR_I == ADDR_CAPABILITY3) |=> RDATA_O[POS_VECTORED_IRQ_PRESENT_BIT_BIT] == 1'b1)
        else $error("vectored bit not one");
    chk_cap_ext_bit: assert property (@(posedge CLK_I) disable iff (RST_I)
        (RD_I && ADDR_I == ADDR_CAPABILITY3)
        |=> RDATA_O[POS_VEXT_BIT] == $past(EXT_CTRL_PRESENT_I))
        else $error("external bit wrong");
    chk_debug_window: assert property (@(posedge CLK_I) disable iff (RST_I)
        ADDR_DEBUG_O |-> (q.priv == PRIV_DEBUG && VADDR_I[31:21] == 11'h7f9))
        else $error("debug window wrong");
    chk_css_in_range: assert property (@(posedge CLK_I) disable iff (RST_I)
        q.current_shadow_set <= HIGHEST_SHADOW_SET) else $error("set above highest");
    chk_debug_priority: assert property (@(posedge CLK_I) disable iff (RST_I)
        EVENT_I.debug_evt |-> ENTRY_KIND_O == 2'h3) else $error("priority wrong");

endmodule : shadow_ctl

`default_nettype wire

// ---- sim/irq_src_model.sv ----
// model of the interrupt sources and the external interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_src_model (
    // bench control
    input  wire logic       clk_i,
    input  wire logic [3:0] src_i,
    input  wire logic [3:0] set_i,
    // toward the block
    output logic      [5:0] hw_o,
    output logic      [1:0] sw_o,
    output logic            tmr_o,
    output logic            present_o,
    output logic      [3:0] set_o
);
    logic [8:0] lv_q = 9'h000;
    assign present_o = 1'b1; // controller attached, static strap
    always_ff @(posedge clk_i) begin
        lv_q  <= (src_i == 4'h0) ? 9'h000 : 9'h001 << (src_i - 4'h1); // one source
        set_o <= set_i; // set number chosen by the controller
    end
    assign {tmr_o, sw_o, hw_o} = lv_q;
endmodule : irq_src_model
`default_nettype wire

// ---- sim/shadow_ctl_tb.sv ----
// self-checking bench of the shadow set controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) cmp(n, 32'(e), 32'(g))
module shadow_ctl_tb import shadow_ctl_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, prev = 1'b0;
    logic [3:0] addr = 4'h0, src = 4'h0, setn = 4'h0;
    logic [31:0] wdata = 32'h0, vaddr = 32'h0, d;
    event_t evt = '0;
    wire logic [31:0] rdata;
    wire logic [5:0] hw;
    wire logic [1:0] sw, kind, mode, priv;
    wire logic [3:0] gset, xset;
    wire logic tmr, pres, pend, a_usr, a_unc, a_dbg;
    int errors = 0, n_compared = 0, cyc = 0;
    localparam logic [4:0] K_DBG = 5'h10, K_IRQ = 5'h04, K_EXC = 5'h02, K_RET = 5'h01;
    logic [34:0] rows [9] = '{{32'h0000_0000, 3'h4}, {32'h7fff_ffff, 3'h4},
        {32'h8000_0000, 3'h0}, {32'h9fff_ffff, 3'h0}, {32'ha000_0000, 3'h2},
        {32'hbfff_ffff, 3'h2}, {32'hc000_0000, 3'h0}, {32'hff20_0000, 3'h0},
        {32'hff3f_ffff, 3'h0}};
    always #2 clk = ~clk;
    irq_src_model part (.clk_i(clk), .src_i(src), .set_i(setn), .hw_o(hw), .sw_o(sw),
        .tmr_o(tmr), .present_o(pres), .set_o(xset));
    shadow_ctl #(.NUM_SETS(4)) dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HW_IRQ_I(hw),
        .SW_IRQ_I(sw), .TIMER_IRQ_I(tmr), .EXT_CTRL_PRESENT_I(pres), .EVENT_I(evt),
        .PREV_SET_ACCESS_I(prev), .IRQ_PENDING_O(pend), .ENTRY_KIND_O(kind),
        .GPR_SET_O(gset), .MODE_O(mode), .PRIV_O(priv), .VADDR_I(vaddr),
        .ADDR_USER_O(a_usr), .ADDR_UNCACHED_O(a_unc), .ADDR_DEBUG_O(a_dbg));
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask : cmp
    task conclude();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a);
        @(posedge clk); addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task fire(input logic [4:0] k, input logic [2:0] v);
        // one extra edge lets the controller model present the set chosen by the bench
        repeat (2) @(posedge clk);
        evt <= event_t'({1'b0, k, v, xset});
        #1 `CHK("entry kind", k[4] ? 2'h3 : (k[2] ? 2'h1 : 2'h0), kind);
        @(posedge clk); evt <= '0;
        #1;
    endtask : fire
    task sets(input logic [3:0] c, input logic [3:0] p);
        rd_reg(ADDR_SHADOW_CTRL);
        `CHK("current set", c, d[3:0]);
        `CHK("previous set", p, d[9:6]);
    endtask : sets
    task dbg_map(input logic [31:0] a, input logic e);
        @(posedge clk); vaddr <= a;
        #1 `CHK("debug segment", e, a_dbg);
    endtask : dbg_map
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        `CHK("mode after reset", MODE_COMPAT, mode);
        rd_reg(ADDR_CAPABILITY3);
        `CHK("vectored present", 1'b1, d[POS_VECTORED_IRQ_PRESENT_BIT_BIT]);
        `CHK("ext present", pres, d[POS_VEXT_BIT]);
        sets(4'h0, 4'h0);
        `CHK("highest set", 4'h3, d[29:26]);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk); vaddr <= rows[i][34:3];
            #1 `CHK("addr class", rows[i][2:0], {a_usr, a_unc, a_dbg});
        end
        $display("test address map done");
        for (int s = 1; s <= 9; s++) begin
            @(posedge clk); src <= 4'(s);
            @(posedge clk); #1 `CHK("irq pending", 1'b1, pend);
        end
        @(posedge clk); src <= 4'h0;
        @(posedge clk); #1 `CHK("irq idle", 1'b0, pend);
        wr_reg(ADDR_VECTOR_MAP, 32'h0000_3020);
        wr_reg(ADDR_SHADOW_CTRL, 32'h0000_2000);
        wr_reg(ADDR_INT_MODE, 32'h1);
        #1 `CHK("mode vectored", MODE_VECTORED, mode);
        fire(K_IRQ, 3'h3);
        sets(4'h3, 4'h0);
        fire(K_EXC, 3'h0);
        sets(4'h2, 4'h3);
        @(posedge clk); prev <= 1'b1;
        #1 `CHK("prev set access", 4'h3, gset);
        @(posedge clk); prev <= 1'b0;
        #1 `CHK("active set", 4'h2, gset);
        fire(K_RET, 3'h0);
        sets(4'h3, 4'h3);
        `CHK("user after return", PRIV_USER, priv);
        dbg_map(32'hff20_0000, 1'b0);
        $display("test vectored done");
        wr_reg(ADDR_INT_MODE, 32'h2);
        #1 `CHK("mode external", MODE_EXTERNAL, mode);
        setn <= 4'h1;
        fire(K_IRQ, 3'h0);
        sets(4'h1, 4'h3);
        setn <= 4'h5;
        fire(K_IRQ, 3'h0);
        sets(4'h0, 4'h1);
        wr_reg(ADDR_INT_MODE, 32'h0);
        fire(K_IRQ, 3'h1);
        sets(4'h2, 4'h0);
        $display("test external and compat done");
        fire(K_DBG, 3'h0);
        `CHK("debug priv", PRIV_DEBUG, priv);
        dbg_map(32'hff20_0000, 1'b1);
        dbg_map(32'hff3f_ffff, 1'b1);
        dbg_map(32'hff40_0000, 1'b0);
        dbg_map(32'hff1f_ffff, 1'b0);
        fire(K_RET, 3'h0);
        `CHK("kernel after debug", PRIV_KERNEL, priv);
        rd_reg(4'hf);
        `CHK("unmapped read", 32'h0, d);
        $display("test debug done");
        conclude();
    end
endmodule : shadow_ctl_tb
`default_nettype wire
